// ---- design/scs_defs.vh ----
// Constants for the sensor channel sequencer.
// Assumes a 250 MHz system clock; included by the sequencer and its FIFO.
// Notes on behaviour
// R1 - After a conversion the next enabled channel above the current one is started, in order 0-1-2-3.
// R2 - When all enabled channels of a set are done, no conversion starts until the rate timer expires.
// R3 - The channel enable is sampled 25 ns before valid falls and that sample picks the next channel.
// R4 - An enable of all zeros sampled before valid falls stops all further conversions.
// R5 - User logic may change the enable at any time; only the sampled value counts.
// R6 - Set starts are spaced by the rate value times 32 us, from 480 to 8128 us.
// R7 - Conversions within a set are spaced about 480 us apart.
// R8 - After the enable goes from zero to non-zero the first conversion completes within 470 us.
// R9 - Valid lasts 1.625 us plus a calibration time of up to 375 ns, at most 2 us.
// R10 - Channel and result are stable at valid rise and held until the next conversion completes.
// R11 - A new set begins at the lowest channel whose enable bit is set at that moment.
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
`define SCS_CLK_MHZ        250
`define SCS_T_SAMPLE_NS    25
`define SCS_CYC_SAMPLE     ((`SCS_T_SAMPLE_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_T_CONV_US      480
`define SCS_CYC_CONV       (`SCS_T_CONV_US * `SCS_CLK_MHZ)
`define SCS_T_FIRST_US     470
`define SCS_CYC_FIRST      (`SCS_T_FIRST_US * `SCS_CLK_MHZ)
`define SCS_T_RATE_UNIT_US 32
`define SCS_CYC_RATE_UNIT  (`SCS_T_RATE_UNIT_US * `SCS_CLK_MHZ)
`define SCS_T_VALID_NS     1625
`define SCS_CYC_VALID      ((`SCS_T_VALID_NS * `SCS_CLK_MHZ + 999) / 1000)
`define SCS_T_CAL_NS       375
`define SCS_CYC_CAL        ((`SCS_T_CAL_NS * `SCS_CLK_MHZ) / 1000)
`define SCS_RATE_MIN       15
`define SCS_RATE_MAX       254
`define SCS_FIFO_DEPTH     32
`define SCS_SYNC_LAT       5
`endif

// ---- design/scs_fifo.v ----
// Synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes one clock; a write while in_ready_o is low is dropped.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = `SCS_FIFO_DEPTH,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clk_sys_i,
  input  wire             reset_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ff;
  reg [AW-1:0]    rd_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;
  integer         i;

  assign in_ready_o  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid_o = (cnt_ff != {(AW+1){1'b0}});
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      wr_ff  <= {AW{1'b0}};
      rd_ff  <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_ff[i] <= {WIDTH{1'b0}};
      end
    end else begin
      if (push) begin
        mem_ff[wr_ff] <= in_data_i;
        wr_ff         <= (wr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= (rd_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ---- design/scs_sequencer.v ----
// Channel sequencer for the temperature/voltage sensor.
// Assumes raw conversion results arrive from the sensor core as a result word per
// conversion end; user fabric drives the enable asynchronously and drains the FIFO.
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_sequencer #(
  parameter RES_W       = 16,
  parameter CYC_CONV    = `SCS_CYC_CONV,
  parameter CYC_FIRST   = `SCS_CYC_FIRST,
  parameter CYC_RATE_U  = `SCS_CYC_RATE_UNIT,
  parameter CYC_VALID   = `SCS_CYC_VALID,
  parameter CYC_SAMPLE  = `SCS_CYC_SAMPLE,
  parameter CYC_CAL     = `SCS_CYC_CAL
) (
  // Clock and reset
  input  wire             clk_sys_i,
  input  wire             reset_i,
  // User control, asynchronous
  input  wire [3:0]       chan_en_i,
  input  wire [7:0]       rate_i,
  // Sensor core
  input  wire [RES_W-1:0] raw_result_i,
  input  wire [8:0]       cal_cycles_i,
  // Timed result outputs
  output reg  [1:0]       chan_o,
  output reg  [RES_W-1:0] result_o,
  output reg              valid_o,
  output reg              conv_start_o,
  // Buffered result stream
  output wire             fifo_valid_o,
  input  wire             fifo_ready_i,
  output wire [RES_W+1:0] fifo_data_o,
  output reg              overrun_o
);
  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam [4:0] ST_IDLE  = 5'b00001;
  localparam [4:0] ST_CONV  = 5'b00010;
  localparam [4:0] ST_VALID = 5'b00100;
  localparam [4:0] ST_WAIT  = 5'b01000;
  localparam [4:0] ST_GAP   = 5'b10000;

  // First result lands CYC_FIRST after the enable pin changed
  localparam [31:0] CYC_LEAD = CYC_FIRST - `SCS_SYNC_LAT - 1;
  // Later valid ends no later than one CYC_CONV after its start
  localparam [31:0] CYC_NEXT = CYC_CONV - CYC_VALID - CYC_CAL - 1;
  localparam [7:0]  RATE_LO  = `SCS_RATE_MIN;
  localparam [7:0]  RATE_HI  = `SCS_RATE_MAX;

  // ------------------------------------------------------------
  // Enable and rate synchronisers
  // ------------------------------------------------------------
  reg  [3:0] en_s1_ff;
  reg  [3:0] en_s2_ff;
  reg  [3:0] en_s3_ff;
  reg  [3:0] en_ff;
  reg  [7:0] rt_s1_ff;
  reg  [7:0] rt_s2_ff;
  reg  [7:0] rt_s3_ff;
  reg  [7:0] rate_ff;
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      en_s1_ff <= 4'h0;
      en_s2_ff <= 4'h0;
      en_s3_ff <= 4'h0;
      en_ff    <= 4'h0;
      rt_s1_ff <= 8'h0F;
      rt_s2_ff <= 8'h0F;
      rt_s3_ff <= 8'h0F;
      rate_ff  <= 8'h0F;
    end else begin
      en_s1_ff <= chan_en_i;
      en_s2_ff <= en_s1_ff;
      en_s3_ff <= en_s2_ff;
      rt_s1_ff <= rate_i;
      rt_s2_ff <= rt_s1_ff;
      rt_s3_ff <= rt_s2_ff;
      if (en_s2_ff == en_s3_ff) begin
        en_ff <= en_s3_ff; // R5
      end
      if (rt_s2_ff == rt_s3_ff) begin
        rate_ff <= rt_s3_ff;
      end
    end
  end

  // Rate clamped to its legal span
  wire [7:0]  rate_cl = (rate_ff < RATE_LO) ? RATE_LO :
                        (rate_ff > RATE_HI) ? RATE_HI : rate_ff;
  wire [31:0] rate_cyc = rate_cl * CYC_RATE_U; // R6

  // ------------------------------------------------------------
  // Next channel pick
  // ------------------------------------------------------------
  reg  [3:0] samp_ff;
  reg  [1:0] cur_ff;
  reg        nxt_found;
  reg  [1:0] nxt_ch;
  reg        low_found;
  reg  [1:0] low_ch;
  integer    k;
  always @* begin
    nxt_found = 1'b0;
    nxt_ch    = 2'd0;
    low_found = 1'b0;
    low_ch    = 2'd0;
    for (k = 3; k >= 0; k = k - 1) begin
      if (samp_ff[k] && (k > cur_ff)) begin
        nxt_found = 1'b1; // R1
        nxt_ch    = k[1:0];
      end
      if (en_ff[k]) begin
        low_found = 1'b1; // R11
        low_ch    = k[1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  reg [4:0]       st_ff;
  reg [31:0]      tmr_ff;
  reg [31:0]      set_ff;
  reg [31:0]      vlen_ff;
  reg [31:0]      gap_ff;
  reg             push_ff;
  wire            fifo_in_ready;
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      st_ff        <= ST_IDLE;
      tmr_ff       <= 32'h0;
      set_ff       <= 32'h0;
      vlen_ff      <= 32'h0;
      gap_ff       <= 32'h0;
      samp_ff      <= 4'h0;
      cur_ff       <= 2'd0;
      chan_o       <= 2'd0;
      result_o     <= {RES_W{1'b0}};
      valid_o      <= 1'b0;
      conv_start_o <= 1'b0;
      push_ff      <= 1'b0;
      overrun_o    <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      push_ff      <= 1'b0;
      if (set_ff != 32'h0) begin
        set_ff <= set_ff - 32'h1;
      end
      if (gap_ff != 32'h0) begin
        gap_ff <= gap_ff - 32'h1;
      end
      // Flag judged at the push itself
      if (push_ff) begin
        overrun_o <= ~fifo_in_ready;
      end
      case (st_ff)
        ST_IDLE: begin
          if (low_found) begin
            cur_ff       <= low_ch;
            tmr_ff       <= CYC_LEAD; // R8
            gap_ff       <= CYC_CONV - 1;
            set_ff       <= rate_cyc - 32'h1;
            conv_start_o <= 1'b1;
            st_ff        <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (tmr_ff != 32'h0) begin
            tmr_ff <= tmr_ff - 32'h1;
          end else begin
            chan_o   <= cur_ff; // R10
            result_o <= raw_result_i;
            valid_o  <= 1'b1;
            push_ff  <= 1'b1;
            vlen_ff  <= CYC_VALID + ((cal_cycles_i > CYC_CAL) ? CYC_CAL : cal_cycles_i) - 1; // R9
            st_ff    <= ST_VALID;
          end
        end
        ST_VALID: begin
          if (vlen_ff == CYC_SAMPLE) begin
            samp_ff <= en_ff; // R3
          end
          if (vlen_ff != 32'h0) begin
            vlen_ff <= vlen_ff - 32'h1;
          end else begin
            valid_o <= 1'b0;
            if (samp_ff == 4'h0) begin
              st_ff <= ST_IDLE; // R4
            end else if (nxt_found) begin
              cur_ff <= nxt_ch; // R1
              if (gap_ff == 32'h0) begin
                tmr_ff       <= CYC_NEXT; // R7
                gap_ff       <= CYC_CONV - 1;
                conv_start_o <= 1'b1;
                st_ff        <= ST_CONV;
              end else begin
                st_ff <= ST_GAP;
              end
            end else begin
              st_ff <= ST_WAIT; // R2
            end
          end
        end
        ST_GAP: begin
          if (gap_ff == 32'h0) begin
            tmr_ff       <= CYC_NEXT; // R7
            gap_ff       <= CYC_CONV - 1;
            conv_start_o <= 1'b1;
            st_ff        <= ST_CONV;
          end
        end
        ST_WAIT: begin
          if ((set_ff == 32'h0) && (gap_ff == 32'h0)) begin
            if (low_found) begin
              cur_ff       <= low_ch; // R11
              tmr_ff       <= CYC_NEXT;
              gap_ff       <= CYC_CONV - 1;
              set_ff       <= rate_cyc - 32'h1; // R6
              conv_start_o <= 1'b1;
              st_ff        <= ST_CONV;
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Result buffer
  // ------------------------------------------------------------
  scs_fifo #(
    .WIDTH (RES_W + 2),
    .DEPTH (`SCS_FIFO_DEPTH),
    .AW    (5)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (push_ff),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({chan_o, result_o}),
    .out_valid_o (fifo_valid_o),
    .out_ready_i (fifo_ready_i),
    .out_data_o  (fifo_data_o)
  );
endmodule

// ---- verif/scs_seq_props.sv ----
// Port checker for the channel sequencer.
// Assumes one clock domain; bound to the sequencer below.
`timescale 1ns/1ps
module scs_seq_props #(
  parameter RES_W     = 16,
  parameter CYC_CONV  = 1,
  parameter CYC_FIRST = 1,
  parameter CYC_VALID = 1,
  parameter CYC_CAL   = 1
) (
  // Clock and reset
  input wire             clk_sys_i,
  input wire             reset_i,
  // Watched ports
  input wire [3:0]       chan_en_i,
  input wire [8:0]       cal_cycles_i,
  input wire [1:0]       chan_o,
  input wire [RES_W-1:0] result_o,
  input wire             valid_o,
  input wire             conv_start_o
);
  int scnt_ff;
  int vcnt_ff;
  int zcnt_ff;
  reg stop_ff;
  int fcnt_ff;
  reg fwait_ff;
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fcnt_ff <= 0;
      fwait_ff <= 1'b0;
      scnt_ff <= 99999;
      vcnt_ff <= 0;
      zcnt_ff <= 0;
      stop_ff <= 1'b0;
    end else begin
      scnt_ff <= conv_start_o ? 1 : scnt_ff + int'(scnt_ff < 99999);
      vcnt_ff <= valid_o ? vcnt_ff + 1 : 0;
      zcnt_ff <= (chan_en_i == 4'h0) ? zcnt_ff + 1 : 0;
      // Zero enable seen well before valid fell
      stop_ff <= (chan_en_i == 4'h0) && (stop_ff || ($fell(valid_o) && zcnt_ff > 20));
      // Cycles since a stopped sequencer saw its enable return
      fwait_ff <= !valid_o && (fwait_ff || (stop_ff && chan_en_i != 4'h0));
      fcnt_ff  <= fwait_ff ? fcnt_ff + 1 : 1;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  valid_width_a: assert property ($fell(valid_o) |->
    vcnt_ff == CYC_VALID + (cal_cycles_i > CYC_CAL ? CYC_CAL : cal_cycles_i)) else $error("bad width");
  first_valid_a: assert property ($rose(valid_o) && fwait_ff |-> fcnt_ff == CYC_FIRST)
    else $error("valid at wrong time");
  conv_spacing_a: assert property (conv_start_o && !fwait_ff |-> scnt_ff >= CYC_CONV)
    else $error("starts too close");
  start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse too long");
  start_idle_a: assert property (conv_start_o |-> !valid_o)
    else $error("start during valid");
  result_hold_a: assert property (!$rose(valid_o) |-> $stable(chan_o) && $stable(result_o))
    else $error("result moved");
  zero_stop_a: assert property (conv_start_o |-> !stop_ff)
    else $error("start after zero enable");
  enable_restart_a: assert property (stop_ff && chan_en_i != 4'h0 |-> ##[1:8] conv_start_o)
    else $error("no start after enable");
  cover property ($rose(valid_o));
  cover property ($rose(stop_ff));
  cover property (conv_start_o && scnt_ff > CYC_CONV);
endmodule
bind scs_sequencer scs_seq_props #(.RES_W(RES_W), .CYC_CONV(CYC_CONV), .CYC_FIRST(CYC_FIRST),
  .CYC_VALID(CYC_VALID), .CYC_CAL(CYC_CAL)) scs_seq_props_inst (.*);

// ---- verif/scs_user_model.sv ----
// User fabric model: drains the result stream into a log.
// Assumes one clock; hold_i stalls it, else ready every other cycle.
`timescale 1ns/1ps
module scs_user_model (
  // Clock and reset
  input  wire        clk_sys_i,
  input  wire        reset_i,
  // Result stream
  input  wire        hold_i,
  input  wire        fifo_valid_i,
  output reg         fifo_ready_o,
  input  wire [17:0] fifo_data_i
);
  logic [17:0] log_q[$];
  always @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      fifo_ready_o <= 1'b0;
    end else begin
      if (fifo_valid_i && fifo_ready_o) log_q.push_back(fifo_data_i);
      fifo_ready_o <= !hold_i && !fifo_ready_o;
    end
  end
endmodule

// ---- verif/sensor_channel_sequencer_bench.sv ----
// Bench: rows of channel masks, then set rate, overrun and drain cases.
// Assumes shortened counts and the stalling user model.
`timescale 1ns/1ps
module sensor_channel_sequencer_bench;
  localparam CONV = 1000;
  localparam FIRST = 400;
  localparam RU = 100;
  typedef struct {logic [3:0] en; logic [8:0] cal; int n; logic [7:0] ch;} scs_row_t;
  scs_row_t rows[4] = '{'{4'hF, 9'h000, 4, 8'hE4}, '{4'h9, 9'h032, 2, 8'h0C},
                       '{4'h6, 9'h0C8, 2, 8'h09}, '{4'h8, 9'h05D, 1, 8'h03}};
  reg          clk_sys_i = 1'b0;
  reg          reset_i = 1'b1;
  reg          hold = 1'b1;
  reg  [3:0]   chan_en_i = 4'h0;
  reg  [7:0]   rate_i = 8'h32;
  reg  [15:0]  raw_result_i = 16'h1234;
  reg  [8:0]   cal_cycles_i = 9'h000;
  wire [1:0]   chan_o;
  wire [15:0]  result_o;
  wire [17:0]  fifo_data_o;
  wire         valid_o, conv_start_o, fifo_valid_o, fifo_ready_i, overrun_o;
  int          error_cnt = 0, comparisons = 0, cyc = 0, r, k;
  int          st[$];
  logic [17:0] exp_q[$];
  scs_sequencer #(.CYC_CONV(CONV), .CYC_FIRST(FIRST), .CYC_RATE_U(RU)) scs_sequencer_inst (
    .clk_sys_i, .reset_i, .chan_en_i, .rate_i, .raw_result_i, .cal_cycles_i, .chan_o,
    .result_o, .valid_o, .conv_start_o, .fifo_valid_o, .fifo_ready_i, .fifo_data_o, .overrun_o);
  scs_user_model scs_user_model_inst (.clk_sys_i, .reset_i, .hold_i(hold),
    .fifo_valid_i(fifo_valid_o), .fifo_ready_o(fifo_ready_i), .fifo_data_i(fifo_data_o));
  always #2 clk_sys_i = ~clk_sys_i;
  // New raw value per conversion; start times logged
  always @(posedge clk_sys_i) begin
    cyc++;
    if (conv_start_o === 1'b1) begin
      st.push_back(cyc);
      raw_result_i <= raw_result_i + 16'h1111;
    end
  end
  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Next valid rise, then channel and result
  task automatic res(input logic [1:0] ch);
    bit low = 1'b0;
    for (int i = 0; i < 6000; i++) begin
      @(posedge clk_sys_i);
      #1;
      if (valid_o === 1'b1 && low) begin
        chk(chan_o, ch);
        chk(result_o, raw_result_i);
        exp_q.push_back({ch, raw_result_i});
        return;
      end
      low = low | (valid_o === 1'b0);
    end
    error_cnt++;
    test_done();
  endtask
  initial begin
    repeat (10) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (r = 0; r < 4; r++) begin
      @(posedge clk_sys_i);
      chan_en_i <= rows[r].en;
      cal_cycles_i <= rows[r].cal;
      for (k = 0; k < rows[r].n; k++) res(2'(rows[r].ch >> (2 * k)));
      @(posedge clk_sys_i);
      chan_en_i <= 4'h0;
      k = st.size();
      repeat (3000) @(posedge clk_sys_i);
      chk(st.size(), k);
    end
    @(posedge clk_sys_i);
    st.delete();
    chan_en_i <= 4'h5;
    res(2'h0);
    res(2'h2);
    repeat (600) @(posedge clk_sys_i);
    chan_en_i <= 4'hC;
    res(2'h2);
    res(2'h3);
    chk(st[1] - st[0], CONV);
    chk(st[2] - st[0], 50 * RU);
    @(posedge clk_sys_i);
    rate_i <= 8'h0F;
    chan_en_i <= 4'hF;
    for (k = 0; k < 20; k++) begin
      res(2'(k));
      repeat (3) @(posedge clk_sys_i);
      #1;
      chk(overrun_o, k == 19);
    end
    @(posedge clk_sys_i);
    chan_en_i <= 4'h0;
    hold <= 1'b0;
    for (k = 0; k < 300 && scs_user_model_inst.log_q.size() < 32; k++) @(posedge clk_sys_i);
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk(scs_user_model_inst.log_q.size(), 32);
    for (k = 0; k < 32; k++) chk(scs_user_model_inst.log_q[k], exp_q[k]);
    chk(fifo_valid_o, 1'b0);
    // Mid-run reset, then a clean restart
    @(posedge clk_sys_i);
    chan_en_i <= 4'h4;
    res(2'h2);
    @(posedge clk_sys_i);
    reset_i <= 1'b1;
    @(posedge clk_sys_i);
    #1;
    chk({valid_o, overrun_o, fifo_valid_o, conv_start_o}, 4'h0);
    chk({chan_o, result_o}, 18'h00000);
    @(posedge clk_sys_i);
    reset_i <= 1'b0;
    res(2'h2);
    test_done();
  end
endmodule
